/* include/xbus_defines.svh */
/*
 Constants for the peripheral-bus select and buffer control block.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef XBUS_DEFINES_SVH
`define XBUS_DEFINES_SVH
`define SA_W            17
`define LA_W            7
`define KBC_DATA_PORT   17'h00060
`define KBC_CMD_PORT    17'h00064
`define RTC_INDEX_PORT  17'h00070
`define RTC_DATA_PORT   17'h00071
`define ROM_LA_TOP      7'h7f
`define ROM_LA_LOW      7'h00
`define ROM_SA_BASE     17'h10000
`define ROM_LOW_BASE    17'h0e000
`define ALE_SYSCLKS     2'h2
`define CSEN_W          4
`define CSEN_RTC        0
`define CSEN_KBC        1
`define CSEN_ROM        2
`define CSEN_PCS        3
`endif

/* include/xbus_pkg.sv */
/*
 Types shared by the peripheral-bus select and buffer control block.
 Assumes the defines header is on the include path.
*/
`include "xbus_defines.svh"
package xbus_pkg;
	typedef struct packed {
		logic ior_n;
		logic iow_n;
		logic memr_n;
		logic memw_n;
	} isa_cmd_s;
	typedef struct packed {
		logic [`LA_W-1:0] la;
		logic [`SA_W-1:0] sa;
	} isa_addr_s;
	typedef struct packed {
		logic [`SA_W-1:0] base;
		logic [`SA_W-1:0] mask;
	} pcs_range_s;
	typedef enum logic [1:0] {
		ORIG_ISA,
		ORIG_PCI,
		ORIG_CPU
	} origin_e;
endpackage

/* design/sync2.sv */
/*
 Two-flop synchroniser for one level.
 Assumes input is asynchronous to clk_in.
*/
`timescale 1ns/1ns
module sync2 (
	input  wire logic clk_in,
	input  wire logic srst_in,
	input  wire logic rst_val_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_reg;
	logic meta_next;
	logic q_next;
	always_comb begin
		meta_next = d_in;
		q_next    = meta_reg;
		if (srst_in) begin
			meta_next = rst_val_in;
			q_next    = rst_val_in;
		end
	end
	always_ff @(posedge clk_in) begin
		meta_reg <= meta_next;
		q_out    <= q_next;
	end
endmodule // sync2

/* design/edge_det.sv */
/*
 Edge detector on a synchronised level.
 Assumes input already on clk_in.
*/
`timescale 1ns/1ns
module edge_det (
	input  wire logic clk_in,
	input  wire logic srst_in,
	input  wire logic d_in,
	output logic      fall_out,
	output logic      rise_out
);
	logic last_reg;
	logic last_next;
	always_comb begin
		last_next = srst_in ? 1'b1 : d_in;
	end
	always_ff @(posedge clk_in) begin
		last_reg <= last_next;
	end
	assign fall_out = last_reg & ~d_in;
	assign rise_out = ~last_reg & d_in;
endmodule // edge_det

/* design/xbus_ctl.sv */
/*
 Peripheral-bus decode and transceiver control: chip selects, direction,
 output enable and clock-chip address latch. Assumes ISA strobes, addresses
 and the system clock arrive asynchronously and are synchronised here.
*/
// Summary of operation
// R1 - Direction asserted on every I/O read, supported device or not.
// R2 - Memory cycles assert direction only for decoded firmware ROM space.
// R3 - PCI-master reads: direction from I/O read or ROM-space memory read falling edge.
// R4 - ISA-master reads: same, memory case only in firmware ROM space.
// R5 - Direction released when the read strobe rises.
// R6 - DMA cycles, read or write: direction from acknowledge falling until it rises; code drops it earlier if IOR or MEMR rises first.
// R7 - Direction held deasserted at all other times.
// R8 - Output enable only for decoded, enabled supported peripherals.
// R9 - Output enable asserted from falling command strobe.
// R10 - Released on command rise, or on address change for ISA masters.
// R11 - Never output enable for a disabled decode space.
// R12 - Programmable select for PCI-master I/O hitting the range register; code also requires pci_subtractive_in high.
// R13 - Programmable select also enables transceiver controls.
// R14 - Firmware ROM select from addresses, never during DMA.
// R15 - Keyboard select for I/O 60h and 64h, never during DMA.
// R16 - Clock-chip select on accesses to I/O 71h.
// R17 - Write to 70h: address latch from write fall, two system clocks.
// R18 - Selects and transceiver controls active low, idle in reset.
`timescale 1ns/1ns
`include "xbus_defines.svh"
module xbus_ctl (
	input  wire logic                      clk_in,
	input  wire logic                      srst_in,
	input  wire xbus_pkg::isa_cmd_s        cmd_in,
	input  wire xbus_pkg::isa_addr_s       addr_in,
	input  wire logic                      dack_n_in,
	input  wire logic                      sysclk_in,
	input  wire xbus_pkg::origin_e         origin_in,
	input  wire logic                      pci_subtractive_in,
	input  wire logic [`CSEN_W-1:0]        chip_select_enable_reg_in,
	input  wire xbus_pkg::pcs_range_s      prog_select_range_reg_in,
	output logic                           xfer_direction_ctl_n_out,
	output logic                           xfer_output_enable_n_out,
	output logic                           programmable_chip_select_n_out,
	output logic                           firmware_rom_select_n_out,
	output logic                           keyboard_ctrl_select_n_out,
	output logic                           clock_chip_select_n_out,
	output logic                           clock_chip_addr_latch_out
);
	import xbus_pkg::*;

	localparam int NS = 7;
	logic [NS-1:0] raw;
	logic [NS-1:0] syn;
	logic [NS-1:0] fall;
	logic [NS-1:0] rise;
	isa_addr_s     a_s1_reg;
	isa_addr_s     a_s2_reg;
	isa_addr_s     a_prev_reg;
	isa_addr_s     a_s1_next;
	isa_addr_s     a_s2_next;
	isa_addr_s     a_prev_next;

	assign raw = {sysclk_in, dack_n_in, cmd_in.memw_n, cmd_in.memr_n,
		cmd_in.iow_n, cmd_in.ior_n, 1'b1};

	// Synchronise and edge-detect strobes
	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_sync
			sync2 u_sync (
				.clk_in     (clk_in),
				.srst_in    (srst_in),
				.rst_val_in (1'b1),
				.d_in       (raw[g]),
				.q_out      (syn[g])
			);
			edge_det u_edge (
				.clk_in   (clk_in),
				.srst_in  (srst_in),
				.d_in     (syn[g]),
				.fall_out (fall[g]),
				.rise_out (rise[g])
			);
		end
	endgenerate

	// Address bus synchroniser
	always_comb begin
		a_s1_next   = addr_in;
		a_s2_next   = a_s1_reg;
		a_prev_next = a_s2_reg;
		if (srst_in) begin
			a_s1_next   = '0;
			a_s2_next   = '0;
			a_prev_next = '0;
		end
	end
	always_ff @(posedge clk_in) begin
		a_s1_reg   <= a_s1_next;
		a_s2_reg   <= a_s2_next;
		a_prev_reg <= a_prev_next;
	end

	logic ior_n;
	logic iow_n;
	logic memr_n;
	logic memw_n;
	logic dack_n;
	assign ior_n  = syn[1];
	assign iow_n  = syn[2];
	assign memr_n = syn[3];
	assign memw_n = syn[4];
	assign dack_n = syn[5];

	// Address decode
	logic dma;
	logic io_cyc;
	logic mem_cyc;
	logic hit_kbc;
	logic hit_rtc;
	logic hit_ale;
	logic hit_rom;
	logic hit_pcs;
	logic en_kbc;
	logic en_rtc;
	logic en_rom;
	logic en_pcs;
	assign dma     = ~dack_n;
	assign io_cyc  = ~ior_n | ~iow_n;
	assign mem_cyc = ~memr_n | ~memw_n;
	assign hit_kbc = (a_s2_reg.sa == `KBC_DATA_PORT) || (a_s2_reg.sa == `KBC_CMD_PORT);
	assign hit_rtc = a_s2_reg.sa == `RTC_DATA_PORT;
	assign hit_ale = a_s2_reg.sa == `RTC_INDEX_PORT;
	assign hit_rom = ((a_s2_reg.la == `ROM_LA_TOP) || (a_s2_reg.la == `ROM_LA_LOW))
		&& (a_s2_reg.sa >= `ROM_LOW_BASE);
	assign hit_pcs = ((a_s2_reg.sa & prog_select_range_reg_in.mask)
		== (prog_select_range_reg_in.base & prog_select_range_reg_in.mask));
	assign en_kbc = chip_select_enable_reg_in[`CSEN_KBC];
	assign en_rtc = chip_select_enable_reg_in[`CSEN_RTC];
	assign en_rom = chip_select_enable_reg_in[`CSEN_ROM];
	assign en_pcs = chip_select_enable_reg_in[`CSEN_PCS];

	// Chip select next values
	logic rom_sel;
	logic kbc_sel;
	logic rtc_sel;
	logic pcs_sel;
	logic periph;
	assign rom_sel = mem_cyc & hit_rom & ~dma & en_rom;                // [R14]
	assign kbc_sel = io_cyc & hit_kbc & ~dma & en_kbc;                 // [R15]
	assign rtc_sel = io_cyc & hit_rtc & ~dma & en_rtc;                 // [R16]
	assign pcs_sel = io_cyc & hit_pcs & ~dma & en_pcs & pci_subtractive_in
		& (origin_in == ORIG_PCI);                                   // [R12]
	assign periph  = rom_sel | kbc_sel | rtc_sel | pcs_sel;           // [R8] [R11] [R13]

	// Direction and output enable
	logic dir_reg;
	logic dir_next;
	logic oe_reg;
	logic oe_next;
	logic dmard_reg;
	logic dmard_next;
	logic [1:0] ale_cnt_reg;
	logic [1:0] ale_cnt_next;
	logic cs_rom_reg;
	logic cs_kbc_reg;
	logic cs_rtc_reg;
	logic cs_pcs_reg;
	logic cs_rom_next;
	logic cs_kbc_next;
	logic cs_rtc_next;
	logic cs_pcs_next;
	logic addr_chg;
	logic cmd_fall;
	logic cmd_rise;
	assign addr_chg = a_s2_reg != a_prev_reg;
	assign cmd_fall = fall[1] | fall[2] | fall[3] | fall[4];
	assign cmd_rise = rise[1] | rise[2] | rise[3] | rise[4];

	always_comb begin
		cs_rom_next = rom_sel;
		cs_kbc_next = kbc_sel;
		cs_rtc_next = rtc_sel;
		cs_pcs_next = pcs_sel;
		if (srst_in) begin
			cs_rom_next = 1'b0;                                       // [R18]
			cs_kbc_next = 1'b0;
			cs_rtc_next = 1'b0;
			cs_pcs_next = 1'b0;
		end
	end

	always_comb begin
		dir_next     = dir_reg;
		oe_next      = oe_reg;
		dmard_next   = dmard_reg;
		ale_cnt_next = ale_cnt_reg;
		if (fall[1]) begin
			dir_next = 1'b1;                                          // [R1] [R3] [R4]
		end
		if (fall[3] && hit_rom && !dma) begin
			dir_next = 1'b1;                                          // [R2] [R3] [R4]
		end
		if (rise[1] || rise[3]) begin
			dir_next = 1'b0;                                          // [R5]
		end
		if (fall[5] && !memr_n) begin
			dmard_next = 1'b1;
		end
		if (fall[5] && !ior_n) begin
			dmard_next = 1'b1;
		end
		if (fall[5]) begin
			dir_next = 1'b1;                                          // [R6]
		end
		if (rise[5]) begin
			dir_next   = 1'b0;                                        // [R6] [R7]
			dmard_next = 1'b0;
		end
		if ((fall[1] || fall[2] || fall[3] || fall[4]) && periph) begin
			oe_next = 1'b1;                                           // [R9] [R13]
		end
		if (origin_in != ORIG_ISA && (rise[1] || rise[2] || rise[3] || rise[4])) begin
			oe_next = 1'b0;                                           // [R10]
		end
		if (origin_in == ORIG_ISA && addr_chg) begin
			oe_next = 1'b0;                                           // [R10]
		end
		if (!periph && !io_cyc && !mem_cyc) begin
			oe_next = 1'b0;                                           // [R11]
		end
		if (fall[2] && hit_ale && !dma) begin
			ale_cnt_next = `ALE_SYSCLKS;                              // [R17]
		end else if (ale_cnt_reg != 2'h0 && rise[6]) begin
			ale_cnt_next = ale_cnt_reg - 2'h1;                        // [R17]
		end
		if (srst_in) begin
			dir_next     = 1'b0;                                      // [R18]
			oe_next      = 1'b0;
			dmard_next   = 1'b0;
			ale_cnt_next = 2'h0;
		end
	end

	always_ff @(posedge clk_in) begin
		dir_reg     <= dir_next;
		oe_reg      <= oe_next;
		dmard_reg   <= dmard_next;
		ale_cnt_reg <= ale_cnt_next;
		cs_rom_reg  <= cs_rom_next;                                   // [R18]
		cs_kbc_reg  <= cs_kbc_next;
		cs_rtc_reg  <= cs_rtc_next;
		cs_pcs_reg  <= cs_pcs_next;
	end

	// Output flops, active low except the address latch
	always_ff @(posedge clk_in) begin
		xfer_direction_ctl_n_out       <= ~dir_reg;                   // [R18]
		xfer_output_enable_n_out       <= ~(oe_reg & ~srst_in);
		programmable_chip_select_n_out <= ~cs_pcs_reg;
		firmware_rom_select_n_out      <= ~cs_rom_reg;
		keyboard_ctrl_select_n_out     <= ~cs_kbc_reg;
		clock_chip_select_n_out        <= ~cs_rtc_reg;
		clock_chip_addr_latch_out      <= ale_cnt_reg != 2'h0;        // [R17]
	end

	// Checks
	rom_no_dma_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R14]
		dma |-> ##1 !cs_rom_reg) else $error("rom select during dma");
	kbc_no_dma_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R15]
		dma |-> ##1 !cs_kbc_reg) else $error("keyboard select during dma");
	dir_ior_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R1]
		fall[1] && !rise[5] |-> ##1 dir_reg) else $error("no direction on io read");
	dir_release_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R5]
		rise[1] && !fall[5] |-> ##1 !dir_reg) else $error("direction held after read");
	dmadir_set_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R6]
		fall[5] && !rise[1] && !rise[3] |-> ##1 dir_reg) else $error("dma direction");
	oe_needs_sel_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R8]
		$rose(oe_reg) |-> $past(periph)) else $error("oe without enabled decode");
	ale_width_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R17]
		$rose(ale_cnt_reg == `ALE_SYSCLKS) |-> ##1 ale_cnt_reg != 2'h0 [*2])
		else $error("latch strobe too short");
	pcs_origin_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R12]
		cs_pcs_reg |-> $past(origin_in == ORIG_PCI)) else $error("pcs wrong origin");
	reset_idle_a: assert property (@(posedge clk_in) // [R18]
		srst_in |-> ##1 xfer_output_enable_n_out) else $error("oe in reset");
	reset_sel_a: assert property (@(posedge clk_in) // [R18]
		srst_in [*2] |-> ##1 (firmware_rom_select_n_out && keyboard_ctrl_select_n_out
		&& clock_chip_select_n_out && programmable_chip_select_n_out
		&& xfer_direction_ctl_n_out && !clock_chip_addr_latch_out))
		else $error("outputs active in reset");
	rtc_no_dma_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R16]
		dma |-> ##1 !cs_rtc_reg) else $error("clock chip select during dma");
	pcs_no_dma_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R12]
		dma |-> ##1 !cs_pcs_reg) else $error("pcs during dma");
	dir_cause_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R7]
		$rose(dir_reg) |-> $past(fall[1] || fall[3] || fall[5]))
		else $error("direction without read or dma");
	rom_dir_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R2]
		fall[3] && !hit_rom && !fall[1] && !fall[5] && !dir_reg |-> ##1 !dir_reg)
		else $error("direction on non rom memory read");
	dma_release_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R6]
		rise[5] |-> ##1 !dir_reg) else $error("direction held after dma");
	oe_disabled_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R11]
		cmd_fall && !periph && !oe_reg |-> ##1 !oe_reg) else $error("oe for disabled space");
	oe_cmd_rel_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R10]
		origin_in != ORIG_ISA && cmd_rise |-> ##1 !oe_reg) else $error("oe held after command");
	oe_addr_rel_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R10]
		origin_in == ORIG_ISA && addr_chg |-> ##1 !oe_reg) else $error("oe held after address");
	pcs_oe_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R13]
		cmd_fall && pcs_sel && !cmd_rise |-> ##1 oe_reg) else $error("no oe with pcs");
	ale_start_a: assert property (@(posedge clk_in) disable iff (srst_in) // [R17]
		fall[2] && hit_ale && !dma |-> ##1 ale_cnt_reg == `ALE_SYSCLKS)
		else $error("latch strobe not started");
	cov_io_read_c: cover property (@(posedge clk_in) fall[1] ##[1:20] rise[1]);
	cov_dma_c: cover property (@(posedge clk_in) fall[5] ##[1:40] rise[5]);
	cov_ale_c: cover property (@(posedge clk_in) ale_cnt_reg == `ALE_SYSCLKS);
	cov_pcs_c: cover property (@(posedge clk_in) cs_pcs_reg && oe_reg);
	cov_isa_addr_c: cover property (@(posedge clk_in)
		origin_in == ORIG_ISA && addr_chg && oe_reg);
endmodule // xbus_ctl

/* verification/xbus_periph_model.sv */
/*
 Peripheral side model: counts selects taken and address latch pulses.
 Assumes selects active low and latch active high, on clk_in.
*/
`timescale 1ns/1ns
module xbus_periph_model (
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	input  wire logic [3:0] sel_n_in,
	input  wire logic       latch_in,
	output logic [7:0]      latch_count_out,
	output logic [7:0]      sel_count_out
);
	logic [3:0] sel_prev;
	logic       latch_prev;
	always_ff @(posedge clk_in) begin
		sel_prev <= sel_n_in;
		latch_prev <= latch_in;
		if (srst_in) begin
			latch_count_out <= 8'h00;
			sel_count_out <= 8'h00;
		end else begin
			// Index taken once per latch pulse
			if (latch_in && !latch_prev)
				latch_count_out <= latch_count_out + 8'h01;
			if ((sel_prev & ~sel_n_in) != 4'h0)
				sel_count_out <= sel_count_out + 8'h01;
		end
	end
endmodule // xbus_periph_model

/* verification/xbus_ctl_tb.sv */
/*
 Self-checking bench: decode cycles, DMA, address change, latch timing.
 Assumes package, defines header and peripheral model compiled first.
*/
`timescale 1ns/1ns
module xbus_ctl_tb;
	import xbus_pkg::*;
	logic       clk;
	logic       srst;
	isa_cmd_s   cmd;
	isa_addr_s  addr;
	logic       dack_n;
	logic       sysclk;
	origin_e    org;
	logic       sub;
	logic [3:0] csen;
	pcs_range_s rng;
	logic [5:0] outs;
	logic       ale;
	logic [7:0] n_ale;
	logic [7:0] n_sel;
	int         n_mismatch;
	int         check_count;
	int         n;
	int         d;
	xbus_ctl xbus_ctl_i (
		.clk_in                         (clk),
		.srst_in                        (srst),
		.cmd_in                         (cmd),
		.addr_in                        (addr),
		.dack_n_in                      (dack_n),
		.sysclk_in                      (sysclk),
		.origin_in                      (org),
		.pci_subtractive_in             (sub),
		.chip_select_enable_reg_in      (csen),
		.prog_select_range_reg_in       (rng),
		.xfer_direction_ctl_n_out       (outs[5]),
		.xfer_output_enable_n_out       (outs[4]),
		.programmable_chip_select_n_out (outs[3]),
		.firmware_rom_select_n_out      (outs[2]),
		.keyboard_ctrl_select_n_out     (outs[1]),
		.clock_chip_select_n_out        (outs[0]),
		.clock_chip_addr_latch_out      (ale)
	);
	xbus_periph_model xbus_periph_model_i (
		.clk_in          (clk),
		.srst_in         (srst),
		.sel_n_in        (outs[3:0]),
		.latch_in        (ale),
		.latch_count_out (n_ale),
		.sel_count_out   (n_sel)
	);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		sysclk = 1'b0;
		forever #160 sysclk = ~sysclk;
	end
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Expected order: dir, oe, pcs, rom, kbc, rtc; 0 is active
	task automatic tcase(input int k, input logic [6:0] la, input logic [16:0] sa,
		input origin_e o, input logic sb, input logic [3:0] en, input logic [5:0] e);
		addr = '{la: la, sa: sa};
		org = o;
		sub = sb;
		csen = en;
		step(3);
		cmd[3-k] = 1'b0;
		step(7);
		check("active", outs, e);
		cmd = 4'hf;
		step(7);
		check("idle", outs, 6'h3f);
		$display("test cycle %0d %h done", k, sa);
	endtask
	initial begin
		n_mismatch = 0;
		check_count = 0;
		srst = 1'b1;
		cmd = 4'hf;
		addr = '0;
		dack_n = 1'b1;
		org = ORIG_PCI;
		sub = 1'b0;
		csen = 4'hf;
		rng = '{base: 17'h00300, mask: 17'h1fff0};
		step(3);
		check("reset", {ale, outs}, 8'h3f);
		step(3);
		srst = 1'b0;
		step(3);
		tcase(0, 7'h00, 17'h00060, ORIG_PCI, 1'b0, 4'hf, 6'h0d);
		tcase(1, 7'h00, 17'h00064, ORIG_CPU, 1'b0, 4'hf, 6'h2d);
		tcase(1, 7'h00, 17'h00064, ORIG_CPU, 1'b0, 4'hd, 6'h3f);
		tcase(0, 7'h00, 17'h00071, ORIG_ISA, 1'b0, 4'hf, 6'h0e);
		tcase(0, 7'h00, 17'h00071, ORIG_PCI, 1'b0, 4'he, 6'h1f);
		tcase(0, 7'h00, 17'h00300, ORIG_PCI, 1'b0, 4'hf, 6'h1f);
		tcase(2, 7'h00, 17'h0f000, ORIG_ISA, 1'b0, 4'hf, 6'h0b);
		tcase(2, 7'h01, 17'h00000, ORIG_PCI, 1'b0, 4'hf, 6'h3f);
		tcase(3, 7'h00, 17'h0f000, ORIG_PCI, 1'b0, 4'hf, 6'h2b);
		tcase(0, 7'h00, 17'h00300, ORIG_PCI, 1'b1, 4'hf, 6'h07);
		tcase(1, 7'h00, 17'h00308, ORIG_PCI, 1'b0, 4'hf, 6'h3f);
		tcase(1, 7'h00, 17'h00308, ORIG_ISA, 1'b1, 4'hf, 6'h3f);
		tcase(1, 7'h00, 17'h00308, ORIG_PCI, 1'b1, 4'h7, 6'h3f);
		d = n_sel;
		addr = '{la: 7'h00, sa: 17'h00060};
		dack_n = 1'b0;
		step(7);
		check("dma", outs, 6'h1f);
		cmd.ior_n = 1'b0;
		step(7);
		check("dma_kbc", outs, 6'h1f);
		cmd = 4'hf;
		dack_n = 1'b1;
		step(7);
		check("dma_end", outs, 6'h3f);
		check("dma_sel", n_sel, d[7:0]);
		$display("test dma done");
		addr = '{la: 7'h00, sa: 17'h00060};
		org = ORIG_ISA;
		step(3);
		cmd.iow_n = 1'b0;
		step(7);
		check("isa_wr", outs, 6'h2d);
		addr.sa = 17'h00061;
		step(7);
		check("addr_chg", outs, 6'h3f);
		cmd = 4'hf;
		step(7);
		$display("test address change done");
		addr.sa = 17'h00070;
		org = ORIG_PCI;
		step(3);
		cmd.iow_n = 1'b0;
		n = 0;
		while (ale !== 1'b1 && n < 10) begin
			step(1);
			n++;
		end
		check("ale_rise", 8'(n <= 6), 8'h01);
		if (n == 10)
			test_done();
		d = 0;
		while (ale === 1'b1 && d < 40) begin
			step(1);
			d++;
		end
		check("ale_len", 8'(d >= 7 && d <= 16), 8'h01);
		cmd = 4'hf;
		step(7);
		check("ale_count", n_ale, 8'h01);
		$display("test address latch done");
		test_done();
	end
endmodule // xbus_ctl_tb
